/* File: rtl/aptc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aptc_map.svh"

// Functional notes
// - 32-bit prescaler feeds a 32-bit up-only counter.
// - source select and clock enable never change in one write.
// - pending flag rises on enable change, drops when safe.
// - prescaler counts while enabled; clear bit zeroes it, reads zero.
// - tap select picks prescaler bit clocking the counter.
// - counter advances once per rising edge of tap bit.
// - plain mode: wraps from all ones to zero, sets wrap flag.
// - clear-on-alarm: alarm match zeroes counter and sets wrap flag.
// - counter value readable; write loads a new value.
// - date mode makes counter a calendar via calendar value.
// - seconds, minutes, 24-hour hours, day from 1, month from 1.
// - year is a 6-bit offset from a chosen leap year.
// - offsets divisible by four get a 29th of February.
// - alarms behave alike in date mode, in packed format.
// - debug halt freezes prescaler and counter unless both allow.
// - while busy, synced writes are ignored and reads give zero.
module aptc_timer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic system_rc_source,
  input wire logic slow_crystal_source,
  input wire logic generic_clock_source,
  input wire logic clock_wr,
  input wire aptc_pkg::aptc_src_t clock_source_select,
  input wire logic clock_enable_wdata,
  input wire logic ctrl_wr,
  input wire logic ctrl_enable,
  input wire logic [4:0] ctrl_counter_tap,
  input wire logic ctrl_date_mode,
  input wire logic ctrl_clear_on_alarm,
  input wire logic ctrl_prescaler_clear,
  input wire logic cv_wr,
  input wire logic [31:0] cv_wdata,
  input wire logic calendar_value_reg_wr,
  input wire logic [31:0] calendar_value_reg_wdata,
  input wire logic alarm_wr,
  input wire logic [31:0] alarm_wdata,
  input wire logic wrap_clear,
  input wire logic debug_halt,
  input wire logic run_in_debug,
  input wire logic peripheral_debug_mask,
  output aptc_pkg::aptc_src_t prescaler_source_select,
  output logic prescaler_clock_enable,
  output logic clock_switch_pending,
  output logic sync_busy,
  output logic wrap_flag,
  output logic counter_tick,
  output logic [31:0] counter_value_reg,
  output logic [31:0] calendar_value_reg,
  output logic [31:0] alarm_value_reg
);
  import aptc_pkg::*;

  // ================================================================
  // source synchronisers
  logic [2:0] src_raw;
  logic [2:0] src_level;
  logic [2:0] src_prev;
  logic [2:0] src_edge;
  assign src_raw = {generic_clock_source, slow_crystal_source,
                    system_rc_source};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_src
      aptc_sync3 aptc_sync3_inst (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(src_raw[gi]),
        .sync_out(src_level[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_prev <= 3'h0;
    end else begin
      src_prev <= src_level;
    end
  end
  assign src_edge = src_level & ~src_prev;

  // ================================================================
  // prescaler clock switching
  aptc_clk_state_t clk_state;
  aptc_clk_state_t next_clk_state;
  logic [3:0] switch_cnt;
  logic [3:0] next_switch_cnt;
  logic clk_on;
  logic next_clk_on;
  aptc_src_t next_sel;
  logic next_en;
  logic next_pend;
  logic prsc_edge;

  always_comb begin
    next_clk_state = clk_state;
    next_switch_cnt = switch_cnt;
    next_clk_on = clk_on;
    next_sel = prescaler_source_select;
    next_en = prescaler_clock_enable;
    next_pend = clock_switch_pending;
    case (clk_state)
      aptc_clk_idle: begin
        if (clock_wr) begin
          if (clock_enable_wdata != prescaler_clock_enable) begin
            // a write touching both fields is dropped whole
            if (clock_source_select == prescaler_source_select) begin
              next_en = clock_enable_wdata;
              next_pend = 1'b1;
              next_switch_cnt = `APTC_CLK_SWITCH_CYCLES;
              next_clk_state = aptc_clk_switch;
            end
          end else if (!prescaler_clock_enable) begin
            // a live clock is never switched under the prescaler
            next_sel = clock_source_select;
          end
        end
      end
      aptc_clk_switch: begin
        if (switch_cnt == 4'h1) begin
          next_clk_on = prescaler_clock_enable;
          next_pend = 1'b0;
          next_clk_state = aptc_clk_idle;
        end else begin
          next_switch_cnt = switch_cnt - 4'h1;
        end
      end
      default: begin
        next_clk_state = aptc_clk_idle;
      end
    endcase
    case (prescaler_source_select)
      aptc_src_rc: prsc_edge = src_edge[0];
      aptc_src_xtal: prsc_edge = src_edge[1];
      aptc_src_gen: prsc_edge = src_edge[2];
      default: prsc_edge = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      clk_state <= aptc_clk_idle;
      switch_cnt <= 4'h0;
      clk_on <= 1'b0;
      prescaler_source_select <= aptc_src_rc;
      prescaler_clock_enable <= 1'b0;
      clock_switch_pending <= 1'b0;
    end else begin
      clk_state <= next_clk_state;
      switch_cnt <= next_switch_cnt;
      clk_on <= next_clk_on;
      prescaler_source_select <= next_sel;
      prescaler_clock_enable <= next_en;
      clock_switch_pending <= next_pend;
    end
  end

  // ================================================================
  // write capture and handshake toward the counting side
  logic accept;
  logic req;
  logic next_req;
  logic fwd1;
  logic fwd2;
  logic seen;
  logic ack1;
  logic ack2;
  logic apply;
  logic next_busy;
  logic sh_ctrl;
  logic next_sh_ctrl;
  logic [8:0] sh_cfg;
  logic [8:0] next_sh_cfg;
  logic sh_ld;
  logic next_sh_ld;
  logic [31:0] sh_ld_data;
  logic [31:0] next_sh_ld_data;
  logic sh_alarm;
  logic next_sh_alarm;
  logic [31:0] sh_alarm_data;
  logic [31:0] next_sh_alarm_data;
  logic sh_wclr;
  logic next_sh_wclr;

  always_comb begin
    accept = !sync_busy &&
             (ctrl_wr || cv_wr || calendar_value_reg_wr || alarm_wr || wrap_clear);
    next_req = req;
    next_busy = sync_busy && (ack2 != req);
    next_sh_ctrl = sh_ctrl;
    next_sh_cfg = sh_cfg;
    next_sh_ld = sh_ld;
    next_sh_ld_data = sh_ld_data;
    next_sh_alarm = sh_alarm;
    next_sh_alarm_data = sh_alarm_data;
    next_sh_wclr = sh_wclr;
    if (accept) begin
      next_req = !req;
      next_busy = 1'b1;
      next_sh_ctrl = ctrl_wr;
      next_sh_cfg = {ctrl_enable, ctrl_counter_tap, ctrl_date_mode,
                     ctrl_clear_on_alarm, ctrl_prescaler_clear};
      next_sh_ld = cv_wr || calendar_value_reg_wr;
      next_sh_ld_data = cv_wr ? cv_wdata : calendar_value_reg_wdata;
      next_sh_alarm = alarm_wr;
      next_sh_alarm_data = alarm_wdata;
      next_sh_wclr = wrap_clear;
    end
  end
  assign apply = fwd2 ^ seen;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      req <= 1'b0;
      fwd1 <= 1'b0;
      fwd2 <= 1'b0;
      seen <= 1'b0;
      ack1 <= 1'b0;
      ack2 <= 1'b0;
      sync_busy <= 1'b0;
      sh_ctrl <= 1'b0;
      sh_cfg <= 9'h000;
      sh_ld <= 1'b0;
      sh_ld_data <= 32'h00000000;
      sh_alarm <= 1'b0;
      sh_alarm_data <= 32'h00000000;
      sh_wclr <= 1'b0;
    end else begin
      req <= next_req;
      fwd1 <= req;
      fwd2 <= fwd1;
      seen <= fwd2;
      ack1 <= seen;
      ack2 <= ack1;
      sync_busy <= next_busy;
      sh_ctrl <= next_sh_ctrl;
      sh_cfg <= next_sh_cfg;
      sh_ld <= next_sh_ld;
      sh_ld_data <= next_sh_ld_data;
      sh_alarm <= next_sh_alarm;
      sh_alarm_data <= next_sh_alarm_data;
      sh_wclr <= next_sh_wclr;
    end
  end

  // ================================================================
  // prescaler, counter and calendar
  logic run_en;
  logic next_run_en;
  logic [4:0] tap_sel;
  logic [4:0] next_tap_sel;
  logic date_mode;
  logic next_date_mode;
  logic clear_on_alarm;
  logic next_clear_on_alarm;
  logic [31:0] alarm;
  logic [31:0] next_alarm;
  logic [31:0] prescaler;
  logic [31:0] next_prescaler;
  logic tap_prev;
  logic next_tap_prev;
  logic [31:0] count;
  logic [31:0] next_count;
  logic [31:0] cal_next;
  logic next_wrap;
  logic frozen;
  logic prsc_run;
  logic tick;
  logic wrap_set;

  aptc_calendar aptc_calendar_inst (
    .cal(count),
    .next_cal(cal_next)
  );

  always_comb begin
    next_run_en = run_en;
    next_tap_sel = tap_sel;
    next_date_mode = date_mode;
    next_clear_on_alarm = clear_on_alarm;
    next_alarm = alarm;
    next_count = count;
    wrap_set = 1'b0;
    frozen = debug_halt && !(run_in_debug && peripheral_debug_mask);
    prsc_run = run_en && clk_on && prsc_edge && !frozen;
    if (apply && sh_ctrl) begin
      {next_run_en, next_tap_sel, next_date_mode,
       next_clear_on_alarm} = sh_cfg[8:1];
    end
    // clear bit is a one-shot; nothing of it is kept to read back
    if (apply && sh_ctrl && sh_cfg[0]) begin
      next_prescaler = 32'h00000000;
    end else if (prsc_run) begin
      next_prescaler = prescaler + `APTC_COUNT_STEP;
    end else begin
      next_prescaler = prescaler;
    end
    next_tap_prev = prescaler[tap_sel];
    tick = run_en && prescaler[tap_sel] && !tap_prev;
    if (apply && sh_alarm) begin
      next_alarm = sh_alarm_data;
    end
    if (apply && sh_ld) begin
      next_count = sh_ld_data;
    end else if (tick) begin
      if (clear_on_alarm && count == alarm) begin
        next_count = `APTC_COUNT_ZERO;
        wrap_set = 1'b1;
      end else if (date_mode) begin
        next_count = cal_next;
      end else if (count == `APTC_COUNT_TOP) begin
        next_count = `APTC_COUNT_ZERO;
        wrap_set = 1'b1;
      end else begin
        next_count = count + `APTC_COUNT_STEP;
      end
    end
    // set wins over a clear landing in the same cycle
    next_wrap = wrap_set || (wrap_flag && !(apply && sh_wclr));
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_en <= 1'b0;
      tap_sel <= 5'h00;
      date_mode <= 1'b0;
      clear_on_alarm <= 1'b0;
      alarm <= 32'h00000000;
      prescaler <= 32'h00000000;
      tap_prev <= 1'b0;
      count <= 32'h00000000;
      wrap_flag <= 1'b0;
      counter_tick <= 1'b0;
      counter_value_reg <= 32'h00000000;
      calendar_value_reg <= 32'h00000000;
      alarm_value_reg <= 32'h00000000;
    end else begin
      run_en <= next_run_en;
      tap_sel <= next_tap_sel;
      date_mode <= next_date_mode;
      clear_on_alarm <= next_clear_on_alarm;
      alarm <= next_alarm;
      prescaler <= next_prescaler;
      tap_prev <= next_tap_prev;
      count <= next_count;
      wrap_flag <= next_wrap;
      counter_tick <= tick;
      counter_value_reg <= next_busy ? 32'h00000000 : next_count;
      calendar_value_reg <= next_busy ? 32'h00000000 : next_count;
      alarm_value_reg <= next_busy ? 32'h00000000 : next_alarm;
    end
  end

  // ================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_handshake;
    sync_busy[*6] ##1 !sync_busy;
  endsequence

  property p_wrap_top;
    tick && !(apply && sh_ld) && !date_mode && !clear_on_alarm &&
      count == `APTC_COUNT_TOP |=> count == `APTC_COUNT_ZERO && wrap_flag;
  endproperty
  a_wrap_top: assert property (p_wrap_top)
    else $error("counter did not wrap with flag");

  property p_step;
    tick && !(apply && sh_ld) && !date_mode && !clear_on_alarm &&
      count != `APTC_COUNT_TOP |=> count == $past(count) + 32'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one");

  property p_hold;
    !tick && !(apply && sh_ld) |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without a tap edge");

  property p_alarm_clear;
    tick && !(apply && sh_ld) && clear_on_alarm && count == alarm
      |=> count == `APTC_COUNT_ZERO && wrap_flag;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("alarm match did not clear counter");

  property p_pending_window;
    $rose(clock_switch_pending) |-> clock_switch_pending[*4] ##1
      !clock_switch_pending;
  endproperty
  a_pending_window: assert property (p_pending_window)
    else $error("pending flag window wrong");

  property p_no_dual_change;
    clock_wr && !clock_switch_pending &&
      clock_source_select != prescaler_source_select &&
      clock_enable_wdata != prescaler_clock_enable
      |=> $stable(prescaler_source_select) && $stable(prescaler_clock_enable);
  endproperty
  a_no_dual_change: assert property (p_no_dual_change)
    else $error("source and enable changed together");

  property p_busy_reads_zero;
    sync_busy |-> counter_value_reg == 32'h0 && alarm_value_reg == 32'h0;
  endproperty
  a_busy_reads_zero: assert property (p_busy_reads_zero)
    else $error("register read nonzero while busy");

  property p_handshake;
    $rose(sync_busy) |-> s_handshake;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("busy window wrong length");

  property p_freeze;
    frozen && !(apply && sh_ctrl) |=> $stable(prescaler);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("prescaler moved during debug halt");

  property p_prsc_inc;
    prsc_run && !(apply && sh_ctrl && sh_cfg[0])
      |=> prescaler == $past(prescaler) + 32'h1;
  endproperty
  a_prsc_inc: assert property (p_prsc_inc)
    else $error("prescaler did not increment");
endmodule : aptc_timer

`default_nettype wire

/* File: rtl/aptc_map.svh */
`ifndef APTC_MAP_SVH
`define APTC_MAP_SVH

// ==================================================================
// counter limits
`define APTC_COUNT_TOP 32'hFFFFFFFF
`define APTC_COUNT_ZERO 32'h00000000
`define APTC_COUNT_STEP 32'h00000001

// ==================================================================
// clock switch timing, in core_clk cycles
`define APTC_CLK_SWITCH_CYCLES 4'h4

// ==================================================================
// packed calendar field positions
`define APTC_CAL_SEC_LSB 0
`define APTC_CAL_SEC_MSB 5
`define APTC_CAL_MIN_LSB 6
`define APTC_CAL_MIN_MSB 11
`define APTC_CAL_HOUR_LSB 12
`define APTC_CAL_HOUR_MSB 16
`define APTC_CAL_DAY_LSB 17
`define APTC_CAL_DAY_MSB 21
`define APTC_CAL_MONTH_LSB 22
`define APTC_CAL_MONTH_MSB 25
`define APTC_CAL_YEAR_LSB 26
`define APTC_CAL_YEAR_MSB 31

// ==================================================================
// calendar limits
`define APTC_SEC_LAST 6'h3B
`define APTC_MIN_LAST 6'h3B
`define APTC_HOUR_LAST 5'h17
`define APTC_DAY_FIRST 5'h01
`define APTC_MONTH_FIRST 4'h1
`define APTC_MONTH_LAST 4'hC

`endif

/* File: rtl/aptc_pkg.sv */
package aptc_pkg;

  // ================================================================
  // prescaler clock sources
  typedef enum logic [1:0] {
    aptc_src_rc = 2'b00,
    aptc_src_xtal = 2'b01,
    aptc_src_bus = 2'b10,
    aptc_src_gen = 2'b11
  } aptc_src_t;

  // ================================================================
  // clock switch states
  typedef enum logic {
    aptc_clk_idle = 1'b0,
    aptc_clk_switch = 1'b1
  } aptc_clk_state_t;

endpackage : aptc_pkg

/* File: rtl/aptc_sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module aptc_sync3 (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic s1;
  logic s2;
  logic s3;
  logic next_out;

  // change is taken only once the last two stages agree
  always_comb begin
    next_out = (s2 == s3) ? s3 : sync_out;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_out;
    end
  end
endmodule : aptc_sync3

`default_nettype wire

/* File: rtl/aptc_calendar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aptc_map.svh"

module aptc_calendar (
  input wire logic [31:0] cal,
  output logic [31:0] next_cal
);
  function automatic logic [4:0] month_days(input logic [3:0] mon,
                                            input logic [5:0] yr);
    case (mon)
      4'h2: month_days = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
      default: month_days = 5'h1F;
    endcase
  endfunction : month_days

  always_comb begin
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [4:0] day;
    logic [3:0] mon;
    logic [5:0] yr;
    sec = cal[`APTC_CAL_SEC_MSB:`APTC_CAL_SEC_LSB];
    min = cal[`APTC_CAL_MIN_MSB:`APTC_CAL_MIN_LSB];
    hour = cal[`APTC_CAL_HOUR_MSB:`APTC_CAL_HOUR_LSB];
    day = cal[`APTC_CAL_DAY_MSB:`APTC_CAL_DAY_LSB];
    mon = cal[`APTC_CAL_MONTH_MSB:`APTC_CAL_MONTH_LSB];
    yr = cal[`APTC_CAL_YEAR_MSB:`APTC_CAL_YEAR_LSB];
    // >= catches values loaded out of range
    if (sec < `APTC_SEC_LAST) begin
      sec = sec + 6'h01;
    end else begin
      sec = 6'h00;
      if (min < `APTC_MIN_LAST) begin
        min = min + 6'h01;
      end else begin
        min = 6'h00;
        if (hour < `APTC_HOUR_LAST) begin
          hour = hour + 5'h01;
        end else begin
          hour = 5'h00;
          if (day < month_days(mon, yr)) begin
            day = day + 5'h01;
          end else begin
            day = `APTC_DAY_FIRST;
            if (mon < `APTC_MONTH_LAST) begin
              mon = mon + 4'h1;
            end else begin
              mon = `APTC_MONTH_FIRST;
              yr = yr + 6'h01;
            end
          end
        end
      end
    end
    next_cal = {yr, mon, day, hour, min, sec};
  end
endmodule : aptc_calendar

`default_nettype wire

/* File: verification/aptc_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module aptc_timer_tb;
  import aptc_pkg::*;

  // ==================================================================
  // stimulus and observed signals
  typedef struct {logic [4:0] tap; logic [31:0] period;} aptc_row_t;
  aptc_row_t rows [5] = '{'{5'h00, 32'h2}, '{5'h01, 32'h4},
    '{5'h02, 32'h8}, '{5'h03, 32'h10}, '{5'h05, 32'h40}};
  logic core_clk, reset, rc_src, xtal_src, gen_src, clock_wr, en_wd;
  aptc_src_t sel_wd, src_sel;
  logic ctrl_wr, c_en, c_date, c_coa, c_prescaler_clear, cv_wr, calendar_value_reg_wr, alarm_wr;
  logic wrap_clear, dbg, rid, pmask;
  logic [4:0] c_tap;
  logic [31:0] cv_wd, calendar_value_reg_wd, al_wd, cv_q, cal_q, al_q, v0, top;
  logic clk_en_q, pend, busy, wrap, tick;
  int error_cnt, checks_done, n, m;

  aptc_timer aptc_timer_inst (
    .core_clk(core_clk), .reset(reset), .system_rc_source(rc_src),
    .slow_crystal_source(xtal_src), .generic_clock_source(gen_src),
    .clock_wr(clock_wr), .clock_source_select(sel_wd),
    .clock_enable_wdata(en_wd), .ctrl_wr(ctrl_wr), .ctrl_enable(c_en),
    .ctrl_counter_tap(c_tap), .ctrl_date_mode(c_date),
    .ctrl_clear_on_alarm(c_coa), .ctrl_prescaler_clear(c_prescaler_clear),
    .cv_wr(cv_wr), .cv_wdata(cv_wd), .calendar_value_reg_wr(calendar_value_reg_wr),
    .calendar_value_reg_wdata(calendar_value_reg_wd), .alarm_wr(alarm_wr), .alarm_wdata(al_wd),
    .wrap_clear(wrap_clear), .debug_halt(dbg), .run_in_debug(rid),
    .peripheral_debug_mask(pmask), .prescaler_source_select(src_sel),
    .prescaler_clock_enable(clk_en_q), .clock_switch_pending(pend),
    .sync_busy(busy), .wrap_flag(wrap), .counter_tick(tick),
    .counter_value_reg(cv_q), .calendar_value_reg(cal_q),
    .alarm_value_reg(al_q)
  );

  // ==================================================================
  // clocks
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // free-running generic source, picked in the last scenario
  always #60 gen_src = ~gen_src;

  // ==================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  function automatic logic [31:0] cal(input int s, mi, h, d, mo, y);
    return {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
  endfunction : cal

  // strobe bits: wrap clear, alarm, calendar, counter, control
  task automatic swr(input logic [4:0] s);
    {wrap_clear, alarm_wr, calendar_value_reg_wr, cv_wr, ctrl_wr} = s;
    cyc(1);
    {wrap_clear, alarm_wr, calendar_value_reg_wr, cv_wr, ctrl_wr} = 5'h00;
    cyc(1);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n >= 20) chk(1'b0, 1'b1);
    cyc(1);
  endtask : swr

  // m ends as the number of cycles the switch flag stayed high
  task automatic cwr(input aptc_src_t s, input logic e);
    sel_wd = s;
    en_wd = e;
    clock_wr = 1'b1;
    cyc(1);
    clock_wr = 1'b0;
    m = (pend === 1'b1) ? 1 : 0;
    cyc(1);
    while (pend === 1'b1 && m < 20) begin
      cyc(1);
      m++;
    end
  endtask : cwr

  task automatic wtick(input int lim);
    n = 0;
    while (tick !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) chk(1'b0, 1'b1);
    cyc(1);
  endtask : wtick

  // tracks the highest count seen until the wrap flag rises
  task automatic wwrap();
    n = 0;
    top = 32'h0;
    while (wrap !== 1'b1 && n < 300) begin
      if (cv_q > top) top = cv_q;
      cyc(1);
      n++;
    end
    cyc(2);
  endtask : wwrap

  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // ==================================================================
  // watchdog, generous against the roughly one thousand cycles expected
  initial begin
    #(25 * 20000);
    error_cnt++;
    conclude();
  end

  // ==================================================================
  // main sequence
  initial begin
    {rc_src, xtal_src, gen_src, clock_wr, en_wd, ctrl_wr, c_en} = 7'h00;
    {c_date, c_coa, c_prescaler_clear, cv_wr, calendar_value_reg_wr, alarm_wr} = 6'h00;
    {wrap_clear, dbg, rid, pmask} = 4'h0;
    {c_tap, cv_wd, calendar_value_reg_wd, al_wd} = '0;
    sel_wd = aptc_src_rc;
    error_cnt = 0;
    checks_done = 0;
    reset = 1'b1;
    cyc(16);
    reset = 1'b0;
    cyc(1);
    chk({src_sel, clk_en_q, pend, busy, wrap}, 32'h0);
    chk(cv_q | al_q, 32'h0);
    // both fields changed at once must be refused
    cwr(aptc_src_bus, 1'b1);
    chk({src_sel, clk_en_q, m[2:0]}, {aptc_src_rc, 1'b0, 3'h0});
    cwr(aptc_src_bus, 1'b0);
    chk({src_sel, m[2:0]}, {aptc_src_bus, 3'h0});
    cwr(aptc_src_bus, 1'b1);
    chk({clk_en_q, m[2:0]}, {1'b1, 3'h4});
    // second write lands while busy and must vanish
    cv_wd = 32'h12345678;
    cv_wr = 1'b1;
    cyc(1);
    cv_wr = 1'b0;
    cyc(1);
    chk(cv_q, 32'h0);
    cv_wd = 32'h00000055;
    cv_wr = 1'b1;
    cyc(1);
    cv_wr = 1'b0;
    m = 2;
    while (busy === 1'b1 && m < 20) begin
      cyc(1);
      m++;
    end
    chk(m, 32'h6);
    chk(cv_q, 32'h12345678);
    // ================================================================
    // tick spacing per tap
    for (int i = 0; i < 5; i++) begin
      c_en = 1'b1;
      c_tap = rows[i].tap;
      swr(5'h01);
      wtick(200);
      v0 = cv_q;
      wtick(200);
      chk(n + 1, rows[i].period);
      chk(cv_q - v0, 32'h1);
    end
    // ================================================================
    // debug freeze: only both permissions keep it running
    c_tap = 5'h00;
    swr(5'h01);
    dbg = 1'b1;
    for (int j = 0; j < 4; j++) begin
      {rid, pmask} = j[1:0];
      cyc(10);
      m = 0;
      repeat (40) begin
        cyc(1);
        if (tick === 1'b1) m++;
      end
      chk(m, (j == 3) ? 32'h14 : 32'h0);
    end
    dbg = 1'b0;
    // ================================================================
    // top wrap, then clear of the flag
    {c_en, c_tap, cv_wd} = {1'b0, 5'h04, 32'hFFFFFFFF};
    swr(5'h03);
    chk(cv_q, 32'hFFFFFFFF);
    c_en = 1'b1;
    swr(5'h01);
    wwrap();
    chk(top, 32'hFFFFFFFF);
    chk(wrap, 1'b1);
    chk(cv_q, 32'h0);
    swr(5'h10);
    chk(wrap, 1'b0);
    // ================================================================
    // clear on alarm: 5, 6, 7 then back to zero
    {c_en, c_tap, c_coa, cv_wd, al_wd} = {1'b0, 5'h03, 1'b1, 32'h5, 32'h7};
    swr(5'h0B);
    chk(al_q, 32'h7);
    c_en = 1'b1;
    swr(5'h01);
    wwrap();
    chk(top, 32'h7);
    chk(wrap, 1'b1);
    chk(cv_q, 32'h0);
    swr(5'h10);
    // ================================================================
    // calendar rollover at end of February, leap and plain year
    for (int y = 4; y < 6; y++) begin
      {c_en, c_coa, c_date} = 3'h1;
      calendar_value_reg_wd = cal(6'h3B, 6'h3B, 5'h17, 5'h1C, 4'h2, y);
      swr(5'h05);
      chk(cal_q, calendar_value_reg_wd);
      // prescaler clear keeps the first tick clear of the busy window
      {c_en, c_prescaler_clear} = 2'h3;
      swr(5'h01);
      c_prescaler_clear = 1'b0;
      wtick(200);
      cyc(1);
      chk(cal_q, (y == 4) ? cal(0, 0, 0, 5'h1D, 4'h2, 4) :
        cal(0, 0, 0, 5'h01, 4'h3, 5));
    end
    // ================================================================
    // stop the prescaler clock
    {c_en, c_date} = 2'h0;
    swr(5'h01);
    cwr(aptc_src_bus, 1'b0);
    chk({clk_en_q, m[2:0]}, {1'b0, 3'h4});
    // other source only while stopped, then restart and count from it
    cwr(aptc_src_gen, 1'b0);
    chk(src_sel, aptc_src_gen);
    cwr(aptc_src_gen, 1'b1);
    chk({clk_en_q, m[2:0]}, {1'b1, 3'h4});
    c_en = 1'b1;
    swr(5'h01);
    wtick(200);
    v0 = cv_q;
    wtick(200);
    chk(cv_q - v0, 32'h1);
    conclude();
  end

endmodule : aptc_timer_tb

`default_nettype wire
